/* sas_sequencer.sv */
// Converter sequencer top: registers, start/abort/complete control, sleep.
// Assumes a synchronous register port, a comparator input and a trigger pulse.
//
// Decided for this implementation: the register offsets and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "sas_params.svh"

module sas_sequencer (
  input  wire logic                 CLK_IN,
  input  wire logic                 SRST_IN,
  input  wire logic [3:0]           ADDR_IN,
  input  wire logic [7:0]           WDATA_IN,
  input  wire logic                 WR_IN,
  input  wire logic                 RD_IN,
  output logic [7:0]                RDATA_OUT,
  input  wire logic                 SLEEP_IN,
  input  wire logic                 TRIGGER_IN,
  input  wire logic                 CMP_IN,
  output logic [9:0]                DAC_TRIAL_OUT,
  output sas_pkg::sas_analog_t      ANALOG_OUT,
  output logic                      IRQ_OUT,
  output logic                      WAKE_OUT,
  output logic                      TIMER_CLEAR_OUT
);

  // ----------------------------------------------------------------------------
  // Declarations.
  // ----------------------------------------------------------------------------
  sas_pkg::sas_bus_t   bus;
  sas_pkg::sas_state_t state_q;
  logic [7:0]          ctrl_q;
  logic [2:0]          clksel_q;
  logic                done_flag_q;
  logic                irq_en_q;
  logic [7:0]          res_high_q;
  logic [7:0]          res_low_q;
  logic [7:0]          rdata_q;
  logic                power_down_q;
  logic                sleep_q;
  logic [3:0]          bit_cnt_q;
  logic [9:0]          wait_cnt_q;
  logic                tick;
  logic                timing;
  logic                conv_start;
  logic [9:0]          sar_value;
  logic [9:0]          sar_trial;
  logic [9:0]          sar_final;
  logic                ctrl_wr;
  logic                go_set_req;
  logic                go_wr_clear;
  logic                complete;
  logic                abort;
  logic                sleep_abort;
  logic                rc_sel;
  logic                busy;

  assign bus = '{addr: ADDR_IN, wdata: WDATA_IN, wr: WR_IN, rd: RD_IN};

  // ----------------------------------------------------------------------------
  // Decoding of control events.
  // ----------------------------------------------------------------------------
  // Clock select code x11 is the internal RC source.
  function automatic logic sas_is_rc(input logic [2:0] sel);
    return sel[1:0] == 2'h3;
  endfunction : sas_is_rc

  assign rc_sel      = sas_is_rc(clksel_q);
  assign ctrl_wr     = bus.wr && bus.addr == `SAS_ADDR_CTRL;
  assign busy        = state_q != sas_pkg::SAS_IDLE && state_q != sas_pkg::SAS_HOLDOFF;
  // A start needs power and a sequencer that is idle or in holdoff; repeated go writes are ignored.
  // A write that turns the converter off cannot start one, even with go set.
  assign go_set_req  = ctrl_q[`SAS_CTRL_ON_BIT] && !busy && !power_down_q &&
                       (TRIGGER_IN || (ctrl_wr && bus.wdata[`SAS_CTRL_GO_BIT])) &&
                       !(ctrl_wr && !bus.wdata[`SAS_CTRL_ON_BIT]);
  assign go_wr_clear = ctrl_wr && !bus.wdata[`SAS_CTRL_GO_BIT];
  assign complete    = state_q == sas_pkg::SAS_CONVERT && tick &&
                       bit_cnt_q == `SAS_BITS_PER_CONV - 4'h1;
  // Sleep without the RC clock kills the conversion; so does a go clear or power off.
  assign sleep_abort = SLEEP_IN && !sleep_q && busy && !rc_sel;
  assign abort       = busy && !complete &&
                       (go_wr_clear || sleep_abort ||
                        (ctrl_wr && !bus.wdata[`SAS_CTRL_ON_BIT]));
  assign conv_start  = state_q == sas_pkg::SAS_DELAY && wait_cnt_q == `SAS_ZERO_CNT;
  assign timing      = state_q == sas_pkg::SAS_CONVERT || state_q == sas_pkg::SAS_HOLDOFF;
  // The last bit is decided on the completing edge, so the result takes it from the comparator.
  assign sar_final   = CMP_IN ? sar_trial : sar_value;

  // ----------------------------------------------------------------------------
  // Bit period generator and approximation register.
  // ----------------------------------------------------------------------------
  sas_tad_gen u_tad (
    .clk_in   (CLK_IN),
    .srst_in  (SRST_IN),
    .run_in   (timing && !abort), // Restart so the holdoff lasts two whole periods.
    .sel_in   (clksel_q),
    .tick_out (tick)
  );

  sas_sar u_sar (
    .clk_in    (CLK_IN),
    .srst_in   (SRST_IN),
    .start_in  (conv_start),
    .step_in   (tick && state_q == sas_pkg::SAS_CONVERT && bit_cnt_q != 4'h0),
    .cmp_in    (CMP_IN),
    .trial_out (sar_trial),
    .value_out (sar_value)
  );

  // ----------------------------------------------------------------------------
  // Sequencer state machine.
  // ----------------------------------------------------------------------------
  // First period holds with no decision, then ten bit decisions; abort enters a holdoff.
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      state_q    <= sas_pkg::SAS_IDLE;
      bit_cnt_q  <= 4'h0;
      wait_cnt_q <= `SAS_ZERO_CNT;
    end else begin
      case (state_q)
        sas_pkg::SAS_IDLE, sas_pkg::SAS_HOLDOFF: begin
          if (state_q == sas_pkg::SAS_HOLDOFF && tick) begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
            if (bit_cnt_q == `SAS_ABORT_TADS - 4'h1) begin
              state_q <= sas_pkg::SAS_IDLE;
            end
          end
          if (go_set_req) begin
            state_q    <= sas_pkg::SAS_DELAY;
            // The RC clock waits one instruction so a sleep can settle noise.
            wait_cnt_q <= rc_sel ? `SAS_INSTR_CYCLES : `SAS_ZERO_CNT;
            bit_cnt_q  <= 4'h0;
          end
        end
        sas_pkg::SAS_DELAY: begin
          if (abort) begin
            state_q   <= sas_pkg::SAS_HOLDOFF;
            bit_cnt_q <= 4'h0;
          end else if (wait_cnt_q == `SAS_ZERO_CNT) begin
            state_q <= sas_pkg::SAS_CONVERT;
          end else begin
            wait_cnt_q <= wait_cnt_q - `SAS_ONE_CNT;
          end
        end
        sas_pkg::SAS_CONVERT: begin
          if (abort) begin
            state_q   <= sas_pkg::SAS_HOLDOFF;
            bit_cnt_q <= 4'h0;
          end else if (complete) begin
            state_q <= sas_pkg::SAS_IDLE;
          end else if (tick) begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end
        end
        default: begin
          state_q <= sas_pkg::SAS_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // Control register and go bit.
  // ----------------------------------------------------------------------------
  // Hardware clear at completion or abort wins over a write and a set; a trigger sets go.
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      ctrl_q <= `SAS_RST_BYTE;
    end else begin
      if (ctrl_wr) begin
        ctrl_q <= (bus.wdata & `SAS_CTRL_WMASK) & ~(8'h01 << `SAS_CTRL_GO_BIT);
        ctrl_q[`SAS_CTRL_GO_BIT] <= busy && bus.wdata[`SAS_CTRL_GO_BIT] && bus.wdata[`SAS_CTRL_ON_BIT];
      end
      if (go_set_req) begin
        ctrl_q[`SAS_CTRL_GO_BIT] <= 1'b1;
      end
      if (complete || abort) begin
        ctrl_q[`SAS_CTRL_GO_BIT] <= 1'b0;
      end
    end
  end

  // Clock select, interrupt enable and sleep edge tracking.
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      clksel_q <= `SAS_RST_CLKSEL;
      irq_en_q <= 1'b0;
      sleep_q  <= 1'b0;
    end else begin
      sleep_q <= SLEEP_IN;
      if (bus.wr && bus.addr == `SAS_ADDR_CLKSEL) begin
        clksel_q <= bus.wdata[`SAS_CLKSEL_MSB:`SAS_CLKSEL_LSB];
      end
      if (bus.wr && bus.addr == `SAS_ADDR_IRQEN) begin
        irq_en_q <= bus.wdata[`SAS_IRQEN_DONE_BIT];
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Completion flag, result and sleep power down.
  // ----------------------------------------------------------------------------
  // A completion in the same cycle as a software clear keeps the flag set.
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      done_flag_q <= 1'b0;
    end else if (complete) begin
      done_flag_q <= 1'b1;
    end else if (bus.wr && bus.addr == `SAS_ADDR_FLAGS && !bus.wdata[`SAS_FLAG_DONE_BIT]) begin
      done_flag_q <= 1'b0;
    end
  end

  // Result registers only change on a whole conversion, never on abort.
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      res_high_q <= `SAS_RST_BYTE;
      res_low_q  <= `SAS_RST_BYTE;
    end else if (complete) begin
      if (ctrl_q[`SAS_CTRL_JUST_BIT]) begin
        res_high_q <= {6'h00, sar_final[9:8]};
        res_low_q  <= sar_final[7:0];
      end else begin
        res_high_q <= sar_final[9:2];
        res_low_q  <= {sar_final[1:0], 6'h00};
      end
    end
  end

  // Sleep power down leaves converter_on readable as one; a new on write restores power.
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      power_down_q <= 1'b0;
    end else if (sleep_abort || (complete && SLEEP_IN && !irq_en_q)) begin
      power_down_q <= 1'b1;
    end else if (ctrl_wr || !SLEEP_IN) begin
      power_down_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------------
  // Read port, one cycle after the strobe.
  // ----------------------------------------------------------------------------
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      rdata_q <= `SAS_RST_BYTE;
    end else if (bus.rd) begin
      case (bus.addr)
        `SAS_ADDR_CTRL:     rdata_q <= ctrl_q;
        `SAS_ADDR_CLKSEL:   rdata_q <= {1'b0, clksel_q, 4'h0};
        `SAS_ADDR_FLAGS:    rdata_q <= {7'h00, done_flag_q};
        `SAS_ADDR_IRQEN:    rdata_q <= {7'h00, irq_en_q};
        `SAS_ADDR_RES_HIGH: rdata_q <= res_high_q;
        `SAS_ADDR_RES_LOW:  rdata_q <= res_low_q;
        default:            rdata_q <= `SAS_RST_BYTE;
      endcase
    end else begin
      rdata_q <= `SAS_RST_BYTE;
    end
  end

  // ----------------------------------------------------------------------------
  // Outputs.
  // ----------------------------------------------------------------------------
  assign RDATA_OUT       = rdata_q;
  assign DAC_TRIAL_OUT   = sar_trial;
  assign IRQ_OUT         = done_flag_q && irq_en_q;
  assign WAKE_OUT        = IRQ_OUT && SLEEP_IN;
  assign TIMER_CLEAR_OUT = TRIGGER_IN && go_set_req;
  assign ANALOG_OUT = '{powered:        ctrl_q[`SAS_CTRL_ON_BIT] && !power_down_q,
                        input_select:   ctrl_q[`SAS_CTRL_CHS_MSB:`SAS_CTRL_CHS_LSB],
                        ref_external:   ctrl_q[`SAS_CTRL_REF_BIT],
                        ref_neg_ground: 1'b1,
                        sampling:       state_q != sas_pkg::SAS_CONVERT &&
                                        state_q != sas_pkg::SAS_HOLDOFF};

endmodule : sas_sequencer
`default_nettype wire

/* sas_params.svh */
// Constants for the converter sequencer: register offsets, field positions,
// reset values and timing counts.
// Assumes inclusion by bare name from the design modules, the checker and the testbench.
`ifndef SAS_PARAMS_SVH
`define SAS_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register offsets on the plain register port.
// ----------------------------------------------------------------------------
`define SAS_ADDR_CTRL      4'h0
`define SAS_ADDR_CLKSEL    4'h1
`define SAS_ADDR_FLAGS     4'h2
`define SAS_ADDR_IRQEN     4'h3
`define SAS_ADDR_RES_HIGH  4'h4
`define SAS_ADDR_RES_LOW   4'h5

// ----------------------------------------------------------------------------
// Field positions in converter_control_reg and the clock select, flag and enable registers.
// ----------------------------------------------------------------------------
`define SAS_CTRL_ON_BIT    0
`define SAS_CTRL_GO_BIT    1
`define SAS_CTRL_CHS_LSB   2
`define SAS_CTRL_CHS_MSB   4
`define SAS_CTRL_REF_BIT   6
`define SAS_CTRL_JUST_BIT  7
`define SAS_CTRL_WMASK     8'hDF
`define SAS_CLKSEL_LSB     4
`define SAS_CLKSEL_MSB     6
`define SAS_FLAG_DONE_BIT  0
`define SAS_IRQEN_DONE_BIT 0

// ----------------------------------------------------------------------------
// Reset values and timing.
// ----------------------------------------------------------------------------
`define SAS_RST_BYTE       8'h00
`define SAS_RST_CLKSEL     3'h0
`define SAS_BITS_PER_CONV  4'hB
`define SAS_ABORT_TADS     4'h2
`define SAS_RC_TAD_CYCLES  10'h3E8
`define SAS_INSTR_CYCLES   10'h004
`define SAS_ZERO_CNT       10'h000
`define SAS_ONE_CNT        10'h001

`endif

/* sas_pkg.sv */
// Types shared by the converter sequencer modules.
// Assumes sas_params.svh is on the include path.
`default_nettype none
package sas_pkg;

  // --------------------------------------------------------------------------
  // Sequencer states.
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    SAS_IDLE,
    SAS_DELAY,
    SAS_CONVERT,
    SAS_HOLDOFF
  } sas_state_t;

  // Analog control bundle driven towards the sample stage and references.
  typedef struct packed {
    logic       powered;
    logic [2:0] input_select;
    logic       ref_external;
    logic       ref_neg_ground;
    logic       sampling;
  } sas_analog_t;

  // Register bus request bundle.
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } sas_bus_t;

endpackage : sas_pkg
`default_nettype wire

/* sas_tad_gen.sv */
// Bit period tick generator for the converter sequencer.
// Assumes one system clock; the internal RC clock is modelled by a counter.
`timescale 1ns/1ps
`default_nettype none
`include "sas_params.svh"

module sas_tad_gen (
  input  wire logic       clk_in,
  input  wire logic       srst_in,
  input  wire logic       run_in,
  input  wire logic [2:0] sel_in,
  output logic            tick_out
);

  logic [9:0] cnt_q;
  logic [9:0] limit;

  // ----------------------------------------------------------------------------
  // Divider selection.
  // ----------------------------------------------------------------------------
  // Maps the clock select code onto a cycle count per bit period.
  function automatic logic [9:0] sas_div(input logic [2:0] sel);
    logic [9:0] r;
    r = `SAS_RC_TAD_CYCLES;
    case (sel)
      3'h0:    r = 10'h002;
      3'h4:    r = 10'h004;
      3'h1:    r = 10'h008;
      3'h5:    r = 10'h010;
      3'h2:    r = 10'h020;
      3'h6:    r = 10'h040;
      default: r = `SAS_RC_TAD_CYCLES; // x11 selects the RC clock.
    endcase
    return r;
  endfunction : sas_div

  assign limit = sas_div(sel_in);

  // Counter restarts whenever the sequencer is not timing, keeping ticks phase aligned.
  always_ff @(posedge clk_in) begin
    if (srst_in || !run_in || cnt_q == limit - `SAS_ONE_CNT) begin
      cnt_q <= `SAS_ZERO_CNT;
    end else begin
      cnt_q <= cnt_q + `SAS_ONE_CNT;
    end
  end

  assign tick_out = run_in && (cnt_q == limit - `SAS_ONE_CNT);

endmodule : sas_tad_gen
`default_nettype wire

/* sas_sar.sv */
// Successive approximation register: one decision per bit period.
// Assumes the comparator input is valid when a tick arrives.
`timescale 1ns/1ps
`default_nettype none
`include "sas_params.svh"

module sas_sar (
  input  wire logic       clk_in,
  input  wire logic       srst_in,
  input  wire logic       start_in,
  input  wire logic       step_in,
  input  wire logic       cmp_in,
  output logic [9:0]      trial_out,
  output logic [9:0]      value_out
);

  logic [9:0] value_q;
  logic [9:0] mask_q;

  // ----------------------------------------------------------------------------
  // Bit decision.
  // ----------------------------------------------------------------------------
  // Keeps or drops the trial bit, then moves to the next lower bit.
  always_ff @(posedge clk_in) begin
    if (srst_in || start_in) begin
      value_q <= 10'h000;
      mask_q  <= 10'h200;
    end else if (step_in && mask_q != 10'h000) begin
      value_q <= cmp_in ? (value_q | mask_q) : value_q;
      mask_q  <= mask_q >> 1;
    end
  end

  assign trial_out = value_q | mask_q;
  assign value_out = value_q;

endmodule : sas_sar
`default_nettype wire

/* sas_checker.sv */
// Port-level checker for the converter sequencer.
// Assumes it is bound onto sas_sequencer, with one clock and a synchronous reset.
`timescale 1ns/1ps
`default_nettype none
`include "sas_params.svh"

module sas_checker (
  input wire logic                 CLK_IN,
  input wire logic                 SRST_IN,
  input wire logic [3:0]           ADDR_IN,
  input wire logic [7:0]           WDATA_IN,
  input wire logic                 WR_IN,
  input wire logic                 SLEEP_IN,
  input wire logic                 TRIGGER_IN,
  input wire logic [9:0]           DAC_TRIAL_OUT,
  input wire sas_pkg::sas_analog_t ANALOG_OUT,
  input wire logic                 IRQ_OUT,
  input wire logic                 WAKE_OUT,
  input wire logic                 TIMER_CLEAR_OUT
);
  // ---------------------------------------------------------------------------
  // Clocking and bus events.
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (SRST_IN);

  // Writes that may legally drop the interrupt level.
  logic flag_wr;
  assign flag_wr = WR_IN && (ADDR_IN == `SAS_ADDR_FLAGS || ADDR_IN == `SAS_ADDR_IRQEN);

  sequence s_ctrl_wr;
    WR_IN && ADDR_IN == `SAS_ADDR_CTRL;
  endsequence

  sequence s_awake_ctrl_wr;
    s_ctrl_wr ##0 !SLEEP_IN;
  endsequence

  // ---------------------------------------------------------------------------
  // Properties.
  // ---------------------------------------------------------------------------
  property p_neg_ref;
    ANALOG_OUT.ref_neg_ground;
  endproperty
  property p_wake;
    WAKE_OUT == (IRQ_OUT && SLEEP_IN);
  endproperty
  property p_timer;
    TIMER_CLEAR_OUT |-> TRIGGER_IN;
  endproperty
  // The flag is never dropped by hardware, so the level only falls on a write.
  property p_irq_hold;
    IRQ_OUT && !flag_wr |=> IRQ_OUT;
  endproperty
  property p_chan;
    s_ctrl_wr |=> ANALOG_OUT.input_select == $past(WDATA_IN[`SAS_CTRL_CHS_MSB:`SAS_CTRL_CHS_LSB]);
  endproperty
  property p_ref;
    s_ctrl_wr |=> ANALOG_OUT.ref_external == $past(WDATA_IN[`SAS_CTRL_REF_BIT]);
  endproperty
  property p_power;
    s_awake_ctrl_wr |=> ANALOG_OUT.powered == $past(WDATA_IN[`SAS_CTRL_ON_BIT]);
  endproperty
  property p_reset;
    $fell(SRST_IN) |-> !IRQ_OUT && !ANALOG_OUT.powered && DAC_TRIAL_OUT == 10'h200;
  endproperty

  a_neg_ref:  assert property (p_neg_ref)  else $error("negative reference left ground");
  a_wake:     assert property (p_wake)     else $error("wake level wrong");
  a_timer:    assert property (p_timer)    else $error("timer clear without trigger");
  a_irq_hold: assert property (p_irq_hold) else $error("interrupt dropped by hardware");
  a_chan:     assert property (p_chan)     else $error("input select not applied");
  a_ref:      assert property (p_ref)      else $error("reference select not applied");
  a_power:    assert property (p_power)    else $error("power does not follow on bit");
  a_reset:    assert property (p_reset)    else $error("outputs not at reset values");
endmodule : sas_checker

bind sas_sequencer sas_checker u_sas_checker (.CLK_IN, .SRST_IN, .ADDR_IN, .WDATA_IN, .WR_IN, .SLEEP_IN,
  .TRIGGER_IN, .DAC_TRIAL_OUT, .ANALOG_OUT, .IRQ_OUT, .WAKE_OUT, .TIMER_CLEAR_OUT);
`default_nettype wire

/* sas_analog_model.sv */
// Behavioural analog front end: input levels per channel and reference.
// Assumes the testbench fills both level tables before each conversion.
`timescale 1ns/1ps
`default_nettype none

module sas_analog_model (
  input  wire logic                 clk_in,
  input  wire sas_pkg::sas_analog_t ana_in,
  input  wire logic [9:0]           trial_in,
  input  wire logic [9:0]           lvl_vdd_in [8],
  input  wire logic [9:0]           lvl_ext_in [8],
  output logic                      cmp_out
);
  logic       junk_q = 1'b0;
  logic [9:0] lvl;

  // An unpowered comparator gives a toggling answer so that nothing is settled by luck.
  always_ff @(posedge clk_in) begin
    junk_q <= ~junk_q;
  end

  // The level sits half a step above its code, so equal means above.
  assign lvl     = ana_in.ref_external ? lvl_ext_in[ana_in.input_select] : lvl_vdd_in[ana_in.input_select];
  assign cmp_out = ana_in.powered ? (lvl >= trial_in) : junk_q;
endmodule : sas_analog_model
`default_nettype wire

/* tb.sv */
// Self-checking testbench for the converter sequencer.
// Assumes sas_checker is bound in and sas_analog_model answers the comparator.
`timescale 1ns/1ps
`default_nettype none
`include "sas_params.svh"

module tb;
  logic                 clk = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0, sleep = 1'b0, trig = 1'b0;
  logic                 cmp, irq, wake, tclr, last_j = 1'b0;
  logic [3:0]           addr = 4'h0;
  logic [7:0]           wdata = 8'h00, rdata;
  logic [9:0]           trial, last_v = 10'h000;
  logic [9:0]           lv_v [8], lv_e [8];
  logic [15:0]          seed = 16'h0036;
  sas_pkg::sas_analog_t ana;
  int                   mismatches = 0, tests_run = 0;

  // Half period of 2 ns gives the 250 MHz system clock.
  always #2 clk = ~clk;

  sas_sequencer u_sas_sequencer (.CLK_IN(clk), .SRST_IN(srst), .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr),
    .RD_IN(rd), .RDATA_OUT(rdata), .SLEEP_IN(sleep), .TRIGGER_IN(trig), .CMP_IN(cmp), .DAC_TRIAL_OUT(trial),
    .ANALOG_OUT(ana), .IRQ_OUT(irq), .WAKE_OUT(wake), .TIMER_CLEAR_OUT(tclr));
  sas_analog_model u_sas_analog_model (.clk_in(clk), .ana_in(ana), .trial_in(trial), .lvl_vdd_in(lv_v),
    .lvl_ext_in(lv_e), .cmp_out(cmp));

  // ---------------------------------------------------------------------------
  // Helpers: random source, expectations, bus cycles and comparisons.
  // ---------------------------------------------------------------------------
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  function automatic int tad(input logic [2:0] s);
    case (s)
      3'h0: return 2;
      3'h4: return 4;
      3'h1: return 8;
      3'h5: return 16;
      3'h2: return 32;
      3'h6: return 64;
      default: return `SAS_RC_TAD_CYCLES;
    endcase
  endfunction : tad
  // Right justified keeps the code low, left justified shifts it to the top.
  function automatic logic [15:0] exp_res(input logic [9:0] v, input logic j);
    return j ? {6'h00, v} : {v, 6'h00};
  endfunction : exp_res
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic chk_bit(input string nm, input logic e, input logic g);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_bit
  // Tasks end just after an edge so no strobe is assigned twice in one step.
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask : wr_reg
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rd_reg
  // Streams flag reads until done shows; the caller's next read takes over the strobe.
  task automatic wait_done(input int lim, output int n);
    n = 0;
    addr <= `SAS_ADDR_FLAGS;
    rd <= 1'b1;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (rdata[`SAS_FLAG_DONE_BIT] !== 1'b1 && n < lim);
    if (n >= lim) begin
      mismatches++;
      $display("BAD wait_done expected 1 seen 0");
      finish_test();
    end
  endtask : wait_done
  task automatic finish_test;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : finish_test

  // ---------------------------------------------------------------------------
  // Scenarios.
  // ---------------------------------------------------------------------------
  task automatic conv(input logic [2:0] s, input logic ie, input logic use_trig, input logic [9:0] v);
    logic [7:0] c, hi, lo;
    int         t, n;
    seed = lfsr(seed);
    c = {seed[7:2], 2'b01};
    t = tad(s);
    lv_v[c[4:2]] = c[6] ? ~v : v;
    lv_e[c[4:2]] = c[6] ? v : ~v;
    wr_reg(`SAS_ADDR_CLKSEL, {1'b0, s, 4'h0});
    wr_reg(`SAS_ADDR_IRQEN, {7'h00, ie});
    wr_reg(`SAS_ADDR_CTRL, c);
    repeat (8) @(posedge clk);
    if (use_trig) begin
      trig <= 1'b1;
      #1;
      chk_bit("timer_clear", 1'b1, tclr);
      @(posedge clk);
      trig <= 1'b0;
    end else begin
      wr_reg(`SAS_ADDR_CTRL, c | 8'h02);
    end
    sleep <= (s[1:0] == 2'b11);
    wait_done(12 * t + 16, n);
    chk_bit("duration", 1'b1, n == 11 * t + 2 + (s[1:0] == 2'b11 ? `SAS_INSTR_CYCLES : 10'h000));
    chk_bit("irq", ie, irq);
    if (s[1:0] == 2'b11) begin
      chk_bit("wake", ie, wake);
      chk_bit("powered", ie, ana.powered);
    end
    sleep <= 1'b0;
    rd_reg(`SAS_ADDR_CTRL, hi);
    chk("ctrl_done", {8'h00, c & 8'hDD}, {8'h00, hi});
    rd_reg(`SAS_ADDR_RES_HIGH, hi);
    rd_reg(`SAS_ADDR_RES_LOW, lo);
    chk("result", exp_res(v, c[7]), {hi, lo});
    wr_reg(`SAS_ADDR_FLAGS, 8'h00);
    last_v = v;
    last_j = c[7];
    $display("test conv %0d done", s);
  endtask : conv

  // Aborts by clearing go or by sleeping on a divided clock; results must not move.
  task automatic abort_case(input logic sl);
    logic [7:0] d, lo;
    wr_reg(`SAS_ADDR_CLKSEL, 8'h60);
    wr_reg(`SAS_ADDR_CTRL, {last_j, 7'h01});
    wr_reg(`SAS_ADDR_CTRL, {last_j, 7'h03});
    repeat (100) @(posedge clk);
    trig <= 1'b1;
    #1;
    chk_bit("busy_trigger", 1'b0, tclr);
    @(posedge clk);
    trig <= 1'b0;
    if (sl) sleep <= 1'b1;
    else wr_reg(`SAS_ADDR_CTRL, {last_j, 7'h01});
    repeat (120) @(posedge clk);
    #1;
    chk_bit("holdoff", 1'b0, ana.sampling);
    repeat (16) @(posedge clk);
    #1;
    chk_bit("acquire", 1'b1, ana.sampling);
    if (sl) chk_bit("sleep_power", 1'b0, ana.powered);
    rd_reg(`SAS_ADDR_CTRL, d);
    chk("ctrl_abort", {8'h00, last_j, 7'h01}, {8'h00, d});
    rd_reg(`SAS_ADDR_FLAGS, d);
    chk("flag_abort", 16'h0000, {8'h00, d});
    rd_reg(`SAS_ADDR_RES_HIGH, d);
    rd_reg(`SAS_ADDR_RES_LOW, lo);
    chk("result_kept", exp_res(last_v, last_j), {d, lo});
    sleep <= 1'b0;
    $display("test abort %0d done", sl);
  endtask : abort_case

  // Main sequence: reset values, every clock code, aborts, refusals, mid-run reset.
  initial begin
    logic [7:0] d;
    for (int k = 0; k < 8; k++) begin
      lv_v[k] = 10'h000;
      lv_e[k] = 10'h000;
    end
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    for (int k = 0; k < 7; k++) begin
      rd_reg(k == 6 ? 4'hF : 4'(k), d);
      chk("reset_value", 16'h0000, {8'h00, d});
    end
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      conv(3'(i), i[2], i == 1, i == 0 ? 10'h000 : i == 4 ? 10'h3FF : seed[9:0]);
    end
    abort_case(1'b0);
    abort_case(1'b1);
    conv(3'h0, 1'b0, 1'b0, 10'h155);
    wr_reg(`SAS_ADDR_CTRL, 8'h02);
    repeat (40) @(posedge clk);
    rd_reg(`SAS_ADDR_CTRL, d);
    chk("go_while_off", 16'h0000, {8'h00, d});
    rd_reg(`SAS_ADDR_FLAGS, d);
    chk("go_while_off_flag", 16'h0000, {8'h00, d});
    wr_reg(`SAS_ADDR_CTRL, 8'h01);
    wr_reg(`SAS_ADDR_CTRL, 8'h03);
    repeat (5) @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rd_reg(`SAS_ADDR_CTRL, d);
    chk("ctrl_after_reset", 16'h0000, {8'h00, d});
    chk_bit("power_after_reset", 1'b0, ana.powered);
    $display("test refusal and reset done");
    finish_test();
  end
endmodule : tb
`default_nettype wire
